// *** rtl/pmeiu_core.sv ***
// Event interrupt unit: debounced event capture, sticky status, mask,
// live sense and one registered interrupt line, behind an AHB-Lite slave.
// Assumes one bus master, single word transfers and an IDLE between them.
//
// Operation
// - Interrupt output high whenever any latched unmasked status bit is set.
// - Status bits stay set after capture until the host clears them.
// - Writing one clears a status bit; zero keeps it; line drops when none.
// - A new event in the clearing cycle still sets; interrupt stays high.
// - Masked bits latch normally but never drive the interrupt output.
// - Masked status bits still read back their latched value.
// - All mask bits are set after reset.
// - Unmasking an already set status bit raises the interrupt at once.
// - Sense bits show live source level, read-only, never latched or cleared.
// - Debounced events need a stable level for the full period; glitches restart.
// - Conversion-done events latch on rising edge with no debounce.
// - Pen contact latches on both edges after one millisecond debounce.
// - Low battery latches on dropping below threshold, programmable debounce; sense.
// - Short trip latches on rising edge after a fixed four ms debounce.
// - Each button latches both edges after 30 ms; sense shows pin high.
// - Button falling debounce extendable by a two-bit setting per button.
// - Clock source change latches both edges undebounced; sense is crystal active.
// - Four thermal comparators latch both edges after 30 ms; sense above.
// - Reset, restart, power cut, warm, retain and clock reset latch rising edge.
// - General inputs have status, mask, sense, programmable edge and debounce.
// - Timekeeping reset event set when the backup domain supply resets.
//
// The address map and the AHB-Lite slave port were left to the implementer.
`timescale 1ns/1ps

module pmeiu_core
    import pmeiu_pkg::*;
#(
    parameter int unsigned TICK_DIV = TICK_CYCLES
) (
    input  wire logic                 hclk,
    input  wire logic                 hresetn,
    input  wire logic                 hsel,
    input  wire logic [31:0]          haddr,
    input  wire logic [1:0]           htrans,
    input  wire logic                 hwrite,
    input  wire logic [2:0]           hsize,
    input  wire logic [31:0]          hwdata,
    input  wire logic                 hready,
    output logic      [31:0]          hrdata,
    output logic                      hreadyout,
    output logic                      hresp,
    input  wire logic                 conv_done,
    input  wire logic                 touch_conv_done,
    input  wire logic                 pen_contact,
    input  wire logic                 batt_below,
    input  wire logic                 short_trip,
    input  wire logic                 second_tick,
    input  wire logic                 alarm_match,
    input  wire logic                 button_a_pin,
    input  wire logic                 button_b_pin,
    input  wire logic                 button_sysreset,
    input  wire logic                 silent_restart,
    input  wire logic                 power_cut,
    input  wire logic                 warm_boot,
    input  wire logic                 mem_retain,
    input  wire logic                 clk_src_xtal,
    input  wire logic                 timekeep_reset,
    input  wire logic [3:0]           temp_above,
    input  wire logic [3:0]           gp_input,
    output logic                      irq
);

    // ==========================================================
    // Slow tick divider
    // ==========================================================
    logic [15:0] div_cnt;
    logic        tick;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            div_cnt <= 16'h0000;
            tick    <= 1'b0;
        end else if (div_cnt == 16'(TICK_DIV - 1)) begin
            div_cnt <= 16'h0000;
            tick    <= 1'b1;
        end else begin
            div_cnt <= div_cnt + 16'h0001;
            tick    <= 1'b0;
        end
    end

    // ==========================================================
    // Registers
    // ==========================================================
    logic [NUM_EVT-1:0] status;
    logic [NUM_EVT-1:0] mask;
    logic [21:0]        config_r;
    logic [NUM_EVT-1:0] evt;
    logic [NUM_EVT-1:0] clr;

    // ==========================================================
    // Source synchronisers
    // ==========================================================
    logic [NUM_EVT-1:0] src;
    logic [NUM_EVT-1:0] sync1;
    logic [NUM_EVT-1:0] sync2;
    logic [1:0]         prime;

    assign src = {gp_input, temp_above, timekeep_reset, clk_src_xtal, mem_retain,
                  warm_boot, power_cut, silent_restart, button_sysreset,
                  button_b_pin, button_a_pin, alarm_match, second_tick,
                  short_trip, batt_below, pen_contact, touch_conv_done, conv_done};

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sync1 <= '0;
            sync2 <= '0;
        end else begin
            sync1 <= src;
            sync2 <= sync1;
        end
    end

    // Settling period lets the stable levels adopt the pins without a
    // spurious edge right after reset (buttons idle high).
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            prime <= 2'h0;
        end else if (prime != PRIME_DONE) begin
            prime <= prime + 2'h1;
        end
    end

    // ==========================================================
    // Per-source trigger edges and debounce targets
    // ==========================================================
    logic [CNT_W-1:0] rise_tgt [NUM_EVT];
    logic [CNT_W-1:0] fall_tgt [NUM_EVT];
    logic [NUM_EVT-1:0] rise_en;
    logic [NUM_EVT-1:0] fall_en;

    always_comb begin
        logic [1:0] sel;
        sel = 2'h0;
        for (int i = 0; i < NUM_EVT; i++) begin
            rise_tgt[i] = '0;
            fall_tgt[i] = '0;
        end
        // rising edge, no debounce by default
        rise_en = '1;
        fall_en = '0;
        fall_en[EV_PEN]  = 1'b1;
        rise_tgt[EV_PEN] = PEN_TICKS;
        fall_tgt[EV_PEN] = PEN_TICKS;
        // source level is "below threshold", so its rise is the drop
        sel = config_r[CF_BATT_SEL +: 2];
        rise_tgt[EV_BATT_LOW] = us_to_ticks(SEL_DEB_US[sel]);
        fall_tgt[EV_BATT_LOW] = us_to_ticks(SEL_DEB_US[sel]);
        rise_tgt[EV_SHORT] = SHORT_TICKS;
        fall_en[EV_BUTTON_A]  = 1'b1;
        fall_en[EV_BUTTON_B]  = 1'b1;
        rise_tgt[EV_BUTTON_A] = SLOW_TICKS;
        rise_tgt[EV_BUTTON_B] = SLOW_TICKS;
        sel = config_r[CF_BTNA_SEL +: 2];
        fall_tgt[EV_BUTTON_A] = us_to_ticks(BTN_FALL_US[sel]);
        sel = config_r[CF_BTNB_SEL +: 2];
        fall_tgt[EV_BUTTON_B] = us_to_ticks(BTN_FALL_US[sel]);
        fall_en[EV_CLK_SRC] = 1'b1;
        for (int k = 0; k < 4; k++) begin
            fall_en[EV_TEMP0 + k]  = 1'b1;
            rise_tgt[EV_TEMP0 + k] = SLOW_TICKS;
            fall_tgt[EV_TEMP0 + k] = SLOW_TICKS;
            sel = config_r[CF_GP_EDGE + 2*k +: 2];
            rise_en[EV_GP0 + k] = (sel == GP_EDGE_RISE) || (sel == GP_EDGE_BOTH);
            fall_en[EV_GP0 + k] = (sel == GP_EDGE_FALL) || (sel == GP_EDGE_BOTH);
            sel = config_r[CF_GP_DEB + 2*k +: 2];
            rise_tgt[EV_GP0 + k] = us_to_ticks(SEL_DEB_US[sel]);
            fall_tgt[EV_GP0 + k] = us_to_ticks(SEL_DEB_US[sel]);
        end
    end

    // ==========================================================
    // Debounce and edge detection, one per source
    // ==========================================================
    logic [NUM_EVT-1:0] stable;
    logic [NUM_EVT-1:0] stable_d;

    genvar g;
    generate
        for (g = 0; g < NUM_EVT; g++) begin : gen_src
            logic [CNT_W-1:0] cnt;
            logic [CNT_W-1:0] tgt;
            assign tgt = sync2[g] ? rise_tgt[g] : fall_tgt[g];
            // level must hold for the whole period; a return restarts
            always_ff @(posedge hclk or negedge hresetn) begin
                if (!hresetn) begin
                    cnt       <= '0;
                    stable[g] <= 1'b0;
                end else if (prime != PRIME_DONE) begin
                    cnt       <= '0;
                    stable[g] <= sync2[g];
                end else if (sync2[g] == stable[g]) begin
                    cnt <= '0;
                end else if (tgt == '0) begin
                    stable[g] <= sync2[g];
                end else if (tick) begin
                    if (cnt + 1'b1 >= tgt) begin
                        cnt       <= '0;
                        stable[g] <= sync2[g];
                    end else begin
                        cnt <= cnt + 1'b1;
                    end
                end
            end
            // Priming adopts the pin here too, so a level held at reset is no edge
            always_ff @(posedge hclk or negedge hresetn) begin
                if (!hresetn) begin
                    stable_d[g] <= 1'b0;
                end else if (prime != PRIME_DONE) begin
                    stable_d[g] <= sync2[g];
                end else begin
                    stable_d[g] <= stable[g];
                end
            end
            assign evt[g] = (prime == PRIME_DONE) &&
                            ((rise_en[g] && stable[g] && !stable_d[g]) ||
                             (fall_en[g] && !stable[g] && stable_d[g]));
        end
    endgenerate

    // ==========================================================
    // AHB-Lite slave, zero wait states
    // ==========================================================
    logic        wr_pend;
    logic [11:0] wr_addr;
    logic [11:0] a_addr;
    logic        a_valid;
    logic [NUM_SENSE-1:0] sense;

    assign a_valid = hsel && htrans[1] && hready;
    assign a_addr  = {haddr[11:2], 2'b00};

    assign sense = {sync2[EV_GP0 +: 4], sync2[EV_TEMP0 +: 4], sync2[EV_CLK_SRC],
                    sync2[EV_BUTTON_B], sync2[EV_BUTTON_A], sync2[EV_BATT_LOW]};

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend   <= 1'b0;
            wr_addr   <= 12'h000;
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end else if (hready) begin
            wr_pend   <= a_valid && hwrite;
            wr_addr   <= a_addr;
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end
    end

    // status reads back regardless of mask
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h0000_0000;
        end else if (a_valid && !hwrite) begin
            unique case (a_addr)
                REG_STATUS: hrdata <= {8'h00, status};
                REG_MASK:   hrdata <= {8'h00, mask};
                REG_SENSE:  hrdata <= {20'h0_0000, sense};
                REG_CONFIG: hrdata <= {10'h000, config_r};
                default:    hrdata <= 32'h0000_0000;
            endcase
        end
    end

    // ==========================================================
    // Status, mask, configuration and interrupt line
    // ==========================================================
    // write one to clear, zero keeps
    assign clr = (wr_pend && wr_addr == REG_STATUS) ? hwdata[NUM_EVT-1:0] : '0;

    // sticky; set wins over clear; mask plays no part
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            status <= '0;
        end else begin
            status <= (status & ~clr) | evt;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            mask <= MASK_RST;
        end else if (wr_pend && wr_addr == REG_MASK) begin
            mask <= hwdata[NUM_EVT-1:0];
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            config_r <= CONFIG_RST;
        end else if (wr_pend && wr_addr == REG_CONFIG) begin
            config_r <= hwdata[21:0];
        end
    end

    // registered OR of unmasked pending bits
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            irq <= 1'b0;
        end else begin
            irq <= |(status & ~mask);
        end
    end

    // ==========================================================
    // Checks
    // ==========================================================
    a_irq_follows_pend: assert property (
        @(posedge hclk) disable iff (!hresetn)
        |(status & ~mask) |=> irq)
        else $error("irq low while an unmasked bit is pending");
    a_irq_drops_clear: assert property (
        @(posedge hclk) disable iff (!hresetn)
        ((status & ~mask) == '0) |=> !irq)
        else $error("irq high with nothing pending");
    a_status_sticky: assert property (
        @(posedge hclk) disable iff (!hresetn)
        ##1 ((($past(status) & ~$past(clr)) & ~status) == '0))
        else $error("status bit lost without a clear");
    a_set_beats_clear: assert property (
        @(posedge hclk) disable iff (!hresetn)
        ((evt != '0) && (clr != '0)) |=> ((status & $past(evt)) == $past(evt)))
        else $error("event lost in clearing cycle");
    a_masked_latch: assert property (
        @(posedge hclk) disable iff (!hresetn)
        ((evt & mask) != '0) |=> ((status & $past(evt & mask)) == $past(evt & mask)))
        else $error("masked event not latched");
    a_mask_reset: assert property (
        @(posedge hclk) disable iff (!hresetn)
        $rose(prime[0]) && prime == 2'h1 |-> mask == MASK_RST)
        else $error("mask not all set after reset");
    a_unmask_raises: assert property (
        @(posedge hclk) disable iff (!hresetn)
        (wr_pend && wr_addr == REG_MASK && ((status & ~hwdata[NUM_EVT-1:0]) != '0))
        |-> ##2 irq)
        else $error("irq not raised after unmask");
    a_status_read: assert property (
        @(posedge hclk) disable iff (!hresetn)
        (a_valid && !hwrite && a_addr == REG_STATUS) |=> hrdata == {8'h00, $past(status)})
        else $error("status read mismatch");
    a_sense_read: assert property (
        @(posedge hclk) disable iff (!hresetn)
        (a_valid && !hwrite && a_addr == REG_SENSE) |=> hrdata == {20'h0_0000, $past(sense)})
        else $error("sense read mismatch");
    a_conv_no_debounce: assert property (
        @(posedge hclk) disable iff (!hresetn)
        (prime == PRIME_DONE && stable_d[EV_CONV_DONE] == stable[EV_CONV_DONE]
         && $rose(sync2[EV_CONV_DONE])) |=> evt[EV_CONV_DONE])
        else $error("conversion done not captured next cycle");
endmodule

// *** inc/pmeiu_pkg.sv ***
// Constants shared by the event interrupt unit: register map, field layout,
// reset values, source numbering and debounce figures.
// Assumes a 250 MHz bus clock and a 32.768 kHz debounce time base.
package pmeiu_pkg;

    // ==========================================================
    // Clocking
    // ==========================================================
    localparam int unsigned CLK_HZ      = 250_000_000;
    localparam int unsigned SLOW_HZ     = 32_768;
    localparam int unsigned TICK_CYCLES = CLK_HZ / SLOW_HZ;

    // ==========================================================
    // Debounce times in microseconds and in slow ticks (rounded up)
    // ==========================================================
    localparam int unsigned CNT_W       = 12;
    localparam int unsigned PEN_DEB_US  = 1_000;
    localparam int unsigned SHORT_DEB_US = 4_000;
    localparam int unsigned SLOW_DEB_US = 30_000;

    function automatic logic [CNT_W-1:0] us_to_ticks(input int unsigned us);
        int unsigned t;
        t = (us * SLOW_HZ + 999_999) / 1_000_000;
        return t[CNT_W-1:0];
    endfunction

    localparam logic [CNT_W-1:0] PEN_TICKS   = us_to_ticks(PEN_DEB_US);
    localparam logic [CNT_W-1:0] SHORT_TICKS = us_to_ticks(SHORT_DEB_US);
    localparam logic [CNT_W-1:0] SLOW_TICKS  = us_to_ticks(SLOW_DEB_US);

    // Selectable debounce values, indexed by a two-bit setting
    localparam int unsigned BTN_FALL_US [4] = '{30_000, 60_000, 90_000, 120_000};
    localparam int unsigned SEL_DEB_US  [4] = '{0, 1_000, 2_000, 4_000};

    // ==========================================================
    // Event sources (bit positions in status and mask)
    // ==========================================================
    localparam int unsigned NUM_EVT        = 24;
    localparam int unsigned EV_CONV_DONE   = 0;
    localparam int unsigned EV_TOUCH_DONE  = 1;
    localparam int unsigned EV_PEN         = 2;
    localparam int unsigned EV_BATT_LOW    = 3;
    localparam int unsigned EV_SHORT       = 4;
    localparam int unsigned EV_TICK        = 5;
    localparam int unsigned EV_ALARM       = 6;
    localparam int unsigned EV_BUTTON_A    = 7;
    localparam int unsigned EV_BUTTON_B    = 8;
    localparam int unsigned EV_SYSRESET    = 9;
    localparam int unsigned EV_RESTART     = 10;
    localparam int unsigned EV_POWER_CUT   = 11;
    localparam int unsigned EV_WARM        = 12;
    localparam int unsigned EV_MEM_RETAIN  = 13;
    localparam int unsigned EV_CLK_SRC     = 14;
    localparam int unsigned EV_TIMEKEEP    = 15;
    localparam int unsigned EV_TEMP0       = 16;
    localparam int unsigned EV_GP0         = 20;

    // ==========================================================
    // Register map (byte addresses) and reset values
    // ==========================================================
    localparam logic [11:0] REG_STATUS = 12'h000;
    localparam logic [11:0] REG_MASK   = 12'h004;
    localparam logic [11:0] REG_SENSE  = 12'h008;
    localparam logic [11:0] REG_CONFIG = 12'h00C;

    localparam logic [NUM_EVT-1:0] MASK_RST   = 24'hFF_FFFF;
    localparam logic [21:0]        CONFIG_RST = 22'h00_0000;

    // Config fields
    localparam int unsigned CF_BATT_SEL  = 0;
    localparam int unsigned CF_BTNA_SEL  = 2;
    localparam int unsigned CF_BTNB_SEL  = 4;
    localparam int unsigned CF_GP_EDGE   = 6;
    localparam int unsigned CF_GP_DEB    = 14;

    // General-purpose input edge select
    localparam logic [1:0] GP_EDGE_RISE = 2'h0;
    localparam logic [1:0] GP_EDGE_FALL = 2'h1;
    localparam logic [1:0] GP_EDGE_BOTH = 2'h2;

    // Sense bits
    localparam int unsigned SN_BATT_LOW = 0;
    localparam int unsigned SN_BUTTON_A = 1;
    localparam int unsigned SN_BUTTON_B = 2;
    localparam int unsigned SN_CLK_XTAL = 3;
    localparam int unsigned SN_TEMP0    = 4;
    localparam int unsigned SN_GP0      = 8;
    localparam int unsigned NUM_SENSE   = 12;

    localparam logic [1:0] PRIME_DONE = 2'h3;

endpackage

// *** tb/pmeiu_host.sv ***
// Host processor model: AHB-Lite master doing single word transfers.
// Assumes one slave whose hreadyout is fed back as hready.
`timescale 1ns/1ps

module pmeiu_host (
    input  wire logic        hclk,
    input  wire logic        hready,
    input  wire logic [31:0] hrdata,
    output logic      [31:0] haddr,
    output logic      [1:0]  htrans,
    output logic             hwrite,
    output logic      [2:0]  hsize,
    output logic      [31:0] hwdata,
    output logic             hung
);
    // ==========================================================
    // Bus cycles
    // ==========================================================
    initial begin
        haddr  = 32'h0000_0000;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize  = 3'h2;
        hwdata = 32'h0000_0000;
        hung   = 1'b0;
    end

    task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d,
                        output logic [31:0] q);
        int n;
        @(posedge hclk);
        haddr  <= a;
        hwrite <= w;
        htrans <= 2'h2;
        n = 0;
        do begin
            @(posedge hclk);
            n++;
        end while (hready !== 1'b1 && n < 64);
        htrans <= 2'h0;
        if (w) hwdata <= d;
        do begin
            @(posedge hclk);
            n++;
        end while (hready !== 1'b1 && n < 128);
        q = hrdata;
        // A stuck slave ends the run instead of hanging it
        if (n >= 64) hung <= 1'b1;
    endtask
endmodule

// *** tb/testbench.sv ***
// Self-checking bench for the event interrupt unit.
// Assumes the design answers with zero wait states and TICK_DIV shortened to 4.
`timescale 1ns/1ps

module testbench
    import pmeiu_pkg::*;
;
    logic        hclk = 1'b0;
    logic        hresetn, hwrite, hready, hresp, irq, hung;
    logic [31:0] haddr, hwdata, hrdata, rdat;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    logic [15:0] src;
    logic [3:0]  temp, gp;
    int          ubits [9] = '{1, 6, 9, 10, 11, 12, 13, 14, 15};
    int          n_errors = 0;
    int          num_checks = 0;

    always #2 hclk = ~hclk;

    pmeiu_host host_u (.hclk(hclk), .hready(hready), .hrdata(hrdata), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hung(hung));

    pmeiu_core #(.TICK_DIV(4)) dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(1'b1),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hready), .hrdata(hrdata), .hreadyout(hready), .hresp(hresp),
        .conv_done(src[0]), .touch_conv_done(src[1]), .pen_contact(src[2]),
        .batt_below(src[3]), .short_trip(src[4]), .second_tick(src[5]),
        .alarm_match(src[6]), .button_a_pin(src[7]), .button_b_pin(src[8]),
        .button_sysreset(src[9]), .silent_restart(src[10]), .power_cut(src[11]),
        .warm_boot(src[12]), .mem_retain(src[13]), .clk_src_xtal(src[14]),
        .timekeep_reset(src[15]), .temp_above(temp), .gp_input(gp), .irq(irq));

    // ==========================================================
    // Helpers
    // ==========================================================
    task automatic conclude();
        $display("checks %0d errors %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic rd(input logic [11:0] a, input logic [31:0] exp);
        host_u.xfer(1'b0, {20'h0_0000, a}, 32'h0000_0000, rdat);
        chk(rdat, exp);
        chk({31'h0, hresp}, 32'h0000_0000);
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        host_u.xfer(1'b1, {20'h0_0000, a}, d, rdat);
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge hclk);
    endtask

    always @(posedge hung) begin
        n_errors++;
        conclude();
    end

    initial begin
        #300000;
        n_errors++;
        conclude();
    end

    // ==========================================================
    // Main sequence
    // ==========================================================
    initial begin
        hresetn = 1'b0;
        src = 16'h0000;
        temp = 4'h0;
        gp = 4'h0;
        tick(2);
        hresetn <= 1'b1;
        tick(8);
        rd(REG_MASK, {8'h00, MASK_RST});
        rd(REG_STATUS, 32'h0000_0000);
        rd(12'h010, 32'h0000_0000);
        src[0] <= 1'b1;
        tick(1);
        src[0] <= 1'b0;
        tick(8);
        rd(REG_STATUS, 32'h0000_0001);
        chk({31'h0, irq}, 32'h0000_0000);
        wr(REG_MASK, 32'h00FF_FFFE);
        tick(2);
        chk({31'h0, irq}, 32'h0000_0001);
        wr(REG_STATUS, 32'h0000_0000);
        rd(REG_STATUS, 32'h0000_0001);
        wr(REG_MASK, 32'h00FF_FFDE);
        src[5] <= 1'b1;
        tick(1);
        wr(REG_STATUS, 32'h0000_0001);
        tick(2);
        rd(REG_STATUS, 32'h0000_0020);
        chk({31'h0, irq}, 32'h0000_0001);
        wr(REG_STATUS, 32'h0000_0020);
        tick(2);
        chk({31'h0, irq}, 32'h0000_0000);
        wr(REG_MASK, 32'h0000_0000);
        foreach (ubits[i]) begin
            src[ubits[i]] <= 1'b1;
            tick(8);
            rd(REG_STATUS, 32'h1 << ubits[i]);
            chk({31'h0, irq}, 32'h0000_0001);
            wr(REG_STATUS, 32'h00FF_FFFF);
        end
        wr(REG_SENSE, 32'h0000_0000);
        rd(REG_SENSE, 32'h0000_0008);
        src[14] <= 1'b0;
        src[3] <= 1'b1;
        tick(12);
        rd(REG_STATUS, 32'h0000_4008);
        rd(REG_SENSE, 32'h0000_0001);
        wr(REG_STATUS, 32'h00FF_FFFF);
        // Short glitch must not qualify, then a held level does
        src[2] <= 1'b1;
        tick(60);
        src[2] <= 1'b0;
        tick(300);
        rd(REG_STATUS, 32'h0000_0000);
        src[2] <= 1'b1;
        tick(100);
        rd(REG_STATUS, 32'h0000_0000);
        tick(60);
        rd(REG_STATUS, 32'h0000_0004);
        wr(REG_STATUS, 32'h00FF_FFFF);
        src[2] <= 1'b0;
        tick(170);
        rd(REG_STATUS, 32'h0000_0004);
        wr(REG_STATUS, 32'h00FF_FFFF);
        src[7] <= 1'b1;
        temp[0] <= 1'b1;
        tick(3700);
        rd(REG_STATUS, 32'h0000_0000);
        tick(400);
        rd(REG_STATUS, 32'h0001_0080);
        rd(REG_SENSE, 32'h0000_0013);
        wr(REG_STATUS, 32'h00FF_FFFF);
        wr(REG_CONFIG, 32'h0000_0004);
        src[7] <= 1'b0;
        tick(4200);
        rd(REG_STATUS, 32'h0000_0000);
        tick(4000);
        rd(REG_STATUS, 32'h0000_0080);
        wr(REG_STATUS, 32'h00FF_FFFF);
        gp[0] <= 1'b1;
        tick(12);
        rd(REG_STATUS, 32'h0010_0000);
        rd(REG_SENSE, 32'h0000_0111);
        // Levels still high across a reset must not look like fresh edges
        hresetn <= 1'b0;
        tick(2);
        hresetn <= 1'b1;
        tick(8);
        rd(REG_MASK, {8'h00, MASK_RST});
        rd(REG_STATUS, 32'h0000_0000);
        rd(REG_SENSE, 32'h0000_0111);
        conclude();
    end
endmodule
